/* sdcd_pkg.sv */
// Shared constants and types for the command and clock-enable decoder.
// Assumes a single 32-bit AHB-Lite master and a memory controller on the pins.
package sdcd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LAST = 8'h08;
  localparam logic [7:0] OFS_MODE0 = 8'h0C;

  // Control fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;

  // Address width, bank count and address bit positions
  localparam int ADDR_W = 16;
  localparam int BANKS = 8;
  localparam int AP_BIT = 10;
  localparam int BL_BIT = 12;

  // Mode register 0 burst length field
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Burst duration in memory clock rising edges
  localparam logic [2:0] BEATS_BL8 = 3'h4;
  localparam logic [2:0] BEATS_BC4 = 3'h2;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_MODE_SET, CMD_REFRESH, CMD_SREF_IN, CMD_SREF_OUT,
    CMD_PRE_ONE, CMD_PRE_ALL, CMD_ACTIVATE, CMD_WRITE, CMD_READ,
    CMD_NOOP, CMD_DESEL, CMD_PDOWN_IN, CMD_PDOWN_OUT, CMD_CAL_LONG, CMD_CAL_SHORT
  } sdcd_cmd_t;

  typedef enum logic [1:0] {
    PS_RUN, PS_PD_ACT, PS_PD_PRE, PS_SREF
  } sdcd_pstate_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [2:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdcd_pins_t;

  typedef struct packed {
    sdcd_cmd_t code;
    logic [2:0] ba;
    logic [ADDR_W-1:0] addr;
    logic auto_pre;
    logic bl8;
    logic cal_init;
  } sdcd_cmd_info_t;

endpackage : sdcd_pkg

/* sdcd_decoder.sv */
// Command decoder and clock-enable state logic with an AHB-Lite register slave.
// Assumes memory pins and memory clock are asynchronous to hclk and slower.
// Overview of operation
// - Commands decode from CS, RAS, CAS, WE, CKE and A10 at memory clock rise, except self-refresh exit.
// - On-die termination input never affects decode or clock-enable transitions.
// - All four strobes low with CKE high is mode set; bank picks register.
// - Activate opens row; precharge closes one or all banks; refresh decoded.
// - Read and write decoded with auto precharge; bursts always run to completion.
// - On-the-fly mode takes A12 as burst length, else fixed programmed length.
// - With CKE high at this and the previous rise, deselect and no-operation each report their own command code; neither changes state.
// - No-operation never cuts short a running operation.
// - Calibration decoded long or short by A10; first long uses initial window.
// - Refresh with CKE falling, no bank open and no burst enters self refresh; stays while CKE low.
// - Self refresh exits on CKE high with deselect or no-op, without clock edge.
// - CKE falling with deselect/no-op enters active or precharge power-down.
// - Idle means no bank open, no burst, CKE high.
// - Power-down does no refresh; exits when CKE rises with deselect or no-op.
// - Precharge to a closed bank is reported as precharge and changes no state.
`timescale 1ns/1ps
`default_nettype none
module sdcd_decoder (
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Memory pins
  input wire logic mem_ck,
  input wire logic mem_reset_n,
  input wire sdcd_pkg::sdcd_pins_t mem_pins,
  // Decoded command events
  output sdcd_pkg::sdcd_cmd_info_t cmd_info,
  output logic cmd_valid,
  output logic cmd_illegal
);

  // Two-flop synchronisers
  logic ck_s1;
  logic [1:0] ck_s2;
  sdcd_pkg::sdcd_pins_t pins_s1, pins_s2;
  logic rst_s1, rst_s2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 2'h0;
      pins_s1 <= '0;
      pins_s2 <= '0;
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      ck_s1 <= mem_ck;
      ck_s2 <= {ck_s2[0], ck_s1};
      pins_s1 <= mem_pins;
      pins_s2 <= pins_s1;
      rst_s1 <= mem_reset_n;
      rst_s2 <= rst_s1;
    end
  end

  logic ck_rise;
  sdcd_pkg::sdcd_pins_t p;
  logic desnop;
  logic [2:0] rcw;
  assign ck_rise = ck_s2[0] & ~ck_s2[1];
  assign p = pins_s2;
  assign rcw = {p.ras_n, p.cas_n, p.we_n};
  assign desnop = p.cs_n | (rcw == 3'h7);

  // Decoder state
  sdcd_pkg::sdcd_pstate_t ps, next_ps;
  localparam int BANKS_W = sdcd_pkg::BANKS;
  logic [BANKS_W-1:0] bank_open, next_bank_open;
  logic [2:0] burst_cnt, next_burst_cnt;
  logic ap_pend, next_ap_pend;
  logic [2:0] ap_bank, next_ap_bank;
  logic cke_prev, next_cke_prev;
  logic [sdcd_pkg::ADDR_W-1:0] mode0, next_mode0;
  logic cal_done, next_cal_done;
  sdcd_pkg::sdcd_cmd_info_t next_cmd_info;
  logic next_cmd_valid, next_cmd_illegal;
  logic ctrl_en, next_ctrl_en;
  logic ill_sticky, next_ill_sticky;
  logic idle;
  logic bad;
  sdcd_pkg::sdcd_cmd_t code;

  assign idle = (bank_open == '0) && (burst_cnt == 3'h0) && p.cke;

  // Odt is carried in the pin group but never read here
  always_comb begin
    next_ps = ps;
    next_bank_open = bank_open;
    next_burst_cnt = burst_cnt;
    next_ap_pend = ap_pend;
    next_ap_bank = ap_bank;
    next_cke_prev = cke_prev;
    next_mode0 = mode0;
    next_cal_done = cal_done;
    code = sdcd_pkg::CMD_NONE;
    bad = 1'b0;
    if (ck_rise) begin
      next_cke_prev = p.cke;
      if (burst_cnt != 3'h0) begin
        next_burst_cnt = burst_cnt - 3'h1;
        if (burst_cnt == 3'h1 && ap_pend) begin
          next_bank_open[ap_bank] = 1'b0;
          next_ap_pend = 1'b0;
        end
      end
    end
    if (ps == sdcd_pkg::PS_SREF) begin
      if (p.cke && desnop) begin
        next_ps = sdcd_pkg::PS_RUN;
        code = sdcd_pkg::CMD_SREF_OUT;
      end else if (p.cke && ck_rise) begin
        bad = 1'b1;
      end
    end else if (ck_rise && ctrl_en) begin
      unique case (ps)
        sdcd_pkg::PS_PD_ACT, sdcd_pkg::PS_PD_PRE: begin
          if (p.cke) begin
            if (desnop) begin
              next_ps = sdcd_pkg::PS_RUN;
              code = sdcd_pkg::CMD_PDOWN_OUT;
            end else begin
              bad = 1'b1;
            end
          end
        end
        sdcd_pkg::PS_RUN: begin
          if (cke_prev && !p.cke) begin
            if (desnop) begin
              next_ps = (bank_open != '0 || burst_cnt != 3'h0) ?
                sdcd_pkg::PS_PD_ACT : sdcd_pkg::PS_PD_PRE;
              code = sdcd_pkg::CMD_PDOWN_IN;
            end else if (rcw == 3'h1 && bank_open == '0 && burst_cnt == 3'h0) begin
              next_ps = sdcd_pkg::PS_SREF;
              code = sdcd_pkg::CMD_SREF_IN;
            end else begin
              bad = 1'b1;
            end
          end else if (!cke_prev || !p.cke) begin
            bad = !desnop;
          end else if (p.cs_n) begin
            code = sdcd_pkg::CMD_DESEL;
          end else begin
            unique case (rcw)
              3'h0: begin
                if (idle) begin
                  code = sdcd_pkg::CMD_MODE_SET;
                  if (p.ba == 3'h0) begin
                    next_mode0 = p.addr;
                  end
                end else begin
                  bad = 1'b1;
                end
              end
              3'h1: begin
                if (idle) begin
                  code = sdcd_pkg::CMD_REFRESH;
                end else begin
                  bad = 1'b1;
                end
              end
              3'h2: begin
                if (p.addr[sdcd_pkg::AP_BIT]) begin
                  code = sdcd_pkg::CMD_PRE_ALL;
                  next_bank_open = '0;
                end else begin
                  code = sdcd_pkg::CMD_PRE_ONE;
                  next_bank_open[p.ba] = 1'b0;
                end
              end
              3'h3: begin
                if (bank_open[p.ba]) begin
                  bad = 1'b1;
                end else begin
                  code = sdcd_pkg::CMD_ACTIVATE;
                  next_bank_open[p.ba] = 1'b1;
                end
              end
              3'h4, 3'h5: begin
                if (!bank_open[p.ba] || burst_cnt != 3'h0) begin
                  bad = 1'b1;
                end else begin
                  code = rcw[0] ? sdcd_pkg::CMD_READ : sdcd_pkg::CMD_WRITE;
                  next_burst_cnt = burst_bl8(mode0[1:0], p.addr[sdcd_pkg::BL_BIT]) ?
                    sdcd_pkg::BEATS_BL8 : sdcd_pkg::BEATS_BC4;
                  next_ap_pend = p.addr[sdcd_pkg::AP_BIT];
                  next_ap_bank = p.ba;
                end
              end
              3'h6: begin
                if (p.addr[sdcd_pkg::AP_BIT]) begin
                  code = sdcd_pkg::CMD_CAL_LONG;
                  next_cal_done = 1'b1;
                end else begin
                  code = sdcd_pkg::CMD_CAL_SHORT;
                end
              end
              3'h7: code = sdcd_pkg::CMD_NOOP;
            endcase
          end
        end
        default: bad = 1'b1;
      endcase
    end
  end

  function automatic logic burst_bl8(input logic [1:0] field, input logic a12);
    burst_bl8 = (field == sdcd_pkg::BL_OTF) ? a12 : (field != sdcd_pkg::BL_FIXED4);
  endfunction : burst_bl8

  always_comb begin
    next_cmd_valid = (code != sdcd_pkg::CMD_NONE);
    next_cmd_illegal = bad;
    next_cmd_info = cmd_info;
    if (code != sdcd_pkg::CMD_NONE) begin
      next_cmd_info.code = code;
      next_cmd_info.ba = p.ba;
      next_cmd_info.addr = p.addr;
      next_cmd_info.auto_pre = p.addr[sdcd_pkg::AP_BIT];
      next_cmd_info.bl8 = burst_bl8(mode0[1:0], p.addr[sdcd_pkg::BL_BIT]);
      next_cmd_info.cal_init = (code == sdcd_pkg::CMD_CAL_LONG) && !cal_done;
    end
  end

  // Memory reset clears the decoder synchronously after the synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ps <= sdcd_pkg::PS_RUN;
      bank_open <= '0;
      burst_cnt <= 3'h0;
      ap_pend <= 1'b0;
      ap_bank <= 3'h0;
      cke_prev <= 1'b0;
      mode0 <= '0;
      cal_done <= 1'b0;
      cmd_info <= '0;
      cmd_valid <= 1'b0;
      cmd_illegal <= 1'b0;
    end else if (!rst_s2) begin
      ps <= sdcd_pkg::PS_RUN;
      bank_open <= '0;
      burst_cnt <= 3'h0;
      ap_pend <= 1'b0;
      ap_bank <= 3'h0;
      cke_prev <= 1'b0;
      mode0 <= '0;
      cal_done <= 1'b0;
      cmd_info <= '0;
      cmd_valid <= 1'b0;
      cmd_illegal <= 1'b0;
    end else begin
      ps <= next_ps;
      bank_open <= next_bank_open;
      burst_cnt <= next_burst_cnt;
      ap_pend <= next_ap_pend;
      ap_bank <= next_ap_bank;
      cke_prev <= next_cke_prev;
      mode0 <= next_mode0;
      cal_done <= next_cal_done;
      cmd_info <= next_cmd_info;
      cmd_valid <= next_cmd_valid;
      cmd_illegal <= next_cmd_illegal;
    end
  end

  // AHB-Lite slave, zero wait states
  logic ap_rd, ap_wr, next_ap_wr;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  assign ap_rd = hsel && hready && htrans[1] && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    next_ap_wr = hsel && hready && htrans[1] && hwrite;
    next_wr_addr = next_ap_wr ? haddr : wr_addr;
    next_ctrl_en = ctrl_en;
    next_ill_sticky = ill_sticky;
    if (ap_wr && wr_addr == sdcd_pkg::OFS_CTRL) begin
      next_ctrl_en = hwdata[sdcd_pkg::CTRL_EN_BIT];
      if (hwdata[sdcd_pkg::CTRL_CLR_BIT]) begin
        next_ill_sticky = 1'b0;
      end
    end
    if (cmd_illegal) begin
      next_ill_sticky = 1'b1;
    end
    next_hrdata = 32'h0;
    if (ap_rd) begin
      unique case (haddr)
        sdcd_pkg::OFS_CTRL: next_hrdata = {31'h0, ctrl_en};
        sdcd_pkg::OFS_STATUS: next_hrdata = {16'h0, 3'h0, cal_done, ill_sticky, idle,
          ps, bank_open};
        sdcd_pkg::OFS_LAST: next_hrdata = {8'h0, cmd_info.code, 1'b0, cmd_info.ba,
          cmd_info.addr};
        sdcd_pkg::OFS_MODE0: next_hrdata = {16'h0, mode0};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      wr_addr <= 8'h00;
      ctrl_en <= sdcd_pkg::CTRL_EN_RST;
      ill_sticky <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      ap_wr <= next_ap_wr;
      wr_addr <= next_wr_addr;
      ctrl_en <= next_ctrl_en;
      ill_sticky <= next_ill_sticky;
      hrdata <= next_hrdata;
    end
  end

  // Checks
  sequence s_cke_fall_desnop;
    ck_rise && ctrl_en && rst_s2 && ps == sdcd_pkg::PS_RUN && cke_prev && !p.cke && desnop;
  endsequence
  sequence s_sref_wait;
    ps == sdcd_pkg::PS_SREF && !p.cke;
  endsequence

  a_pd_active_in: assert property (@(posedge hclk) disable iff (!hresetn)
    s_cke_fall_desnop and (bank_open != '0) |=> ps == sdcd_pkg::PS_PD_ACT)
    else $error("active power-down not entered");
  a_pd_pre_in: assert property (@(posedge hclk) disable iff (!hresetn)
    s_cke_fall_desnop and (bank_open == '0 && burst_cnt == 3'h0) |=> ps == sdcd_pkg::PS_PD_PRE)
    else $error("precharge power-down not entered");
  a_sref_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    s_sref_wait and rst_s2 |=> ps == sdcd_pkg::PS_SREF && bank_open == $past(bank_open))
    else $error("self refresh left while cke low");
  a_sref_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    ps == sdcd_pkg::PS_SREF && p.cke && desnop && rst_s2 |=>
    ps == sdcd_pkg::PS_RUN && cmd_valid && cmd_info.code == sdcd_pkg::CMD_SREF_OUT)
    else $error("self refresh exit missed");
  a_pd_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ps == sdcd_pkg::PS_PD_ACT || ps == sdcd_pkg::PS_PD_PRE) && !p.cke && rst_s2 |=>
    ps == $past(ps) && !(cmd_valid && cmd_info.code == sdcd_pkg::CMD_REFRESH))
    else $error("power-down not held");
  a_burst_runs: assert property (@(posedge hclk) disable iff (!hresetn)
    burst_cnt != 3'h0 && !ck_rise && rst_s2 |=> burst_cnt == $past(burst_cnt))
    else $error("burst count moved without clock edge");
  a_burst_len: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_valid && (cmd_info.code == sdcd_pkg::CMD_READ || cmd_info.code == sdcd_pkg::CMD_WRITE)
    |-> burst_cnt == (cmd_info.bl8 ? sdcd_pkg::BEATS_BL8 : sdcd_pkg::BEATS_BC4))
    else $error("burst length wrong");
  a_act_opens: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_valid && cmd_info.code == sdcd_pkg::CMD_ACTIVATE |-> bank_open[cmd_info.ba])
    else $error("activate did not open bank");
  a_mode_store: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_valid && cmd_info.code == sdcd_pkg::CMD_MODE_SET && cmd_info.ba == 3'h0
    |-> mode0 == cmd_info.addr)
    else $error("mode register not stored");
  a_illegal_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_illegal |=> ill_sticky)
    else $error("illegal command not flagged");

endmodule : sdcd_decoder
`default_nettype wire

/* sdcd_ctrl_model.sv */
// Memory controller model driving the command pins and the memory clock.
// Assumes the bench calls its tasks; the clock only runs during a command.
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl_model (
  // Memory side
  output logic mem_ck,
  output logic mem_reset_n,
  output var sdcd_pkg::sdcd_pins_t mem_pins
);
  initial begin
    mem_ck = 1'h0;
    mem_reset_n = 1'h0;
    mem_pins = '0;
  end
  // One clock cycle per command, pins settled mid low phase
  task automatic issue(input sdcd_pkg::sdcd_pins_t p);
    #3;
    mem_pins = p;
    #80;
    mem_ck = 1'h1;
    #77;
    mem_ck = 1'h0;
  endtask : issue
  // Pin change with no clock edge
  task automatic setp(input sdcd_pkg::sdcd_pins_t p);
    #3;
    mem_pins = p;
  endtask : setp
  // Reset starts low; held high in normal use, low again only on request
  task automatic set_rst(input logic v);
    #3;
    mem_reset_n = v;
  endtask : set_rst
endmodule : sdcd_ctrl_model
`default_nettype wire

/* tb_sdcd_decoder.sv */
// Self-checking bench for the command and clock-enable decoder.
// Assumes the controller model owns the memory pins; the bench owns the bus.
`timescale 1ns/1ps
`default_nettype none
module tb_sdcd_decoder;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic mem_ck;
  logic mem_reset_n;
  sdcd_pkg::sdcd_pins_t mem_pins;
  sdcd_pkg::sdcd_cmd_info_t cmd_info;
  logic cmd_valid;
  logic cmd_illegal;
  int error_cnt = 0;
  int compares = 0;
  int seed = 14584;
  int nv = 0;
  int ni = 0;
  int v0;
  int k;
  logic [31:0] rd;
  logic [15:0] ra;
  localparam logic [3:0] C_MRS = 4'h0, C_REF = 4'h1, C_PRE = 4'h2, C_ACT = 4'h3;
  localparam logic [3:0] C_WR = 4'h4, C_RD = 4'h5, C_ZQ = 4'h6, C_NOP = 4'h7, C_DES = 4'h8;
  localparam sdcd_pkg::sdcd_cmd_t NONE = sdcd_pkg::CMD_NONE;

  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (cmd_valid === 1'h1) nv <= nv + 1;
    if (cmd_illegal === 1'h1) ni <= ni + 1;
  end

  sdcd_ctrl_model u_ctl (.mem_ck(mem_ck), .mem_reset_n(mem_reset_n), .mem_pins(mem_pins));
  sdcd_decoder DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_ck(mem_ck), .mem_reset_n(mem_reset_n),
    .mem_pins(mem_pins), .cmd_info(cmd_info), .cmd_valid(cmd_valid),
    .cmd_illegal(cmd_illegal)
  );

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // Waits for a rising edge with ready high
  task automatic wt;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'h1 && i < 50);
    if (hreadyout !== 1'h1) begin
      error_cnt++;
      give_verdict();
    end
  endtask : wt

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "okay");
  endtask : ahb

  // Power state and open banks
  task automatic st(input logic [9:0] e, input string m);
    ahb(1'h0, sdcd_pkg::OFS_STATUS, 32'h0);
    chk({22'h0, rd[9:0]}, {22'h0, e}, m);
  endtask : st

  function automatic sdcd_pkg::sdcd_pins_t mk(input logic c, input logic [3:0] s,
      input logic [2:0] b, input logic [15:0] a);
    logic [3:0] cc;
    cc = s;
    if (cc[3]) cc[2:0] = 3'($random(seed));
    return {c, cc, 1'($random(seed)), b, a};
  endfunction : mk

  // One memory command, then count pulses and check the decoded code
  task automatic cmd(input sdcd_pkg::sdcd_pins_t p, input sdcd_pkg::sdcd_cmd_t e,
      input logic il, input string m);
    int i0;
    v0 = nv;
    i0 = ni;
    u_ctl.issue(p);
    repeat (6) @(posedge hclk);
    chk(ni - i0, {31'h0, il}, m);
    if (!il) chk(nv - v0, (e == NONE) ? 0 : 1, m);
    if (!il && e != NONE) chk({28'h0, cmd_info.code}, {28'h0, e}, m);
  endtask : cmd

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    u_ctl.set_rst(1'h1);
    repeat (4) @(posedge hclk);
    ahb(1'h0, sdcd_pkg::OFS_CTRL, 32'h0);
    chk(rd & 32'h1, 32'h1, "ctrl reset");
    ahb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped");
    u_ctl.issue(mk(1'h1, C_NOP, 3'h0, 16'h0));
    $display("test reset done");
    cmd(mk(1'h1, C_NOP, 3'h0, 16'h0), sdcd_pkg::CMD_NOOP, 1'h0, "nop");
    cmd(mk(1'h1, C_DES, 3'h0, 16'h0), sdcd_pkg::CMD_DESEL, 1'h0, "des");
    cmd(mk(1'h1, C_MRS, 3'h0, 16'h0001), sdcd_pkg::CMD_MODE_SET, 1'h0, "mrs");
    ahb(1'h0, sdcd_pkg::OFS_MODE0, 32'h0);
    chk(rd & 32'hFFFF, 32'h1, "mode0");
    for (k = 0; k < 2; k++) begin
      cmd(mk(1'h1, C_ZQ, 3'h0, 16'h0400), sdcd_pkg::CMD_CAL_LONG, 1'h0, "zqcl");
      chk(cmd_info.cal_init, (k == 0), "cal init");
    end
    cmd(mk(1'h1, C_ZQ, 3'h0, 16'h0), sdcd_pkg::CMD_CAL_SHORT, 1'h0, "zqcs");
    ra = 16'($random(seed));
    cmd(mk(1'h1, C_ACT, 3'h2, ra), sdcd_pkg::CMD_ACTIVATE, 1'h0, "act");
    chk(cmd_info.addr, ra, "row");
    ahb(1'h0, sdcd_pkg::OFS_LAST, 32'h0);
    chk(rd, {8'h0, 4'(sdcd_pkg::CMD_ACTIVATE), 1'h0, 3'h2, ra}, "last");
    st(10'h004, "bank2");
    cmd(mk(1'h1, C_ACT, 3'h2, ra), NONE, 1'h1, "act open");
    cmd(mk(1'h1, C_RD, 3'h2, 16'h0), sdcd_pkg::CMD_READ, 1'h0, "rd");
    chk(cmd_info.bl8, 1'h0, "otf bc4");
    cmd(mk(1'h1, C_RD, 3'h2, 16'h0), NONE, 1'h1, "rd burst");
    cmd(mk(1'h1, C_NOP, 3'h0, 16'h0), sdcd_pkg::CMD_NOOP, 1'h0, "nop");
    cmd(mk(1'h1, C_WR, 3'h2, 16'h1400), sdcd_pkg::CMD_WRITE, 1'h0, "wr");
    chk({cmd_info.auto_pre, cmd_info.bl8}, 2'h3, "ap bl8");
    cmd(mk(1'h1, C_NOP, 3'h0, 16'h0), sdcd_pkg::CMD_NOOP, 1'h0, "nop");
    cmd(mk(1'h1, C_RD, 3'h2, 16'h0), NONE, 1'h1, "wr burst");
    repeat (4) u_ctl.issue(mk(1'h1, C_NOP, 3'h0, 16'h0));
    st(10'h000, "auto pre");
    $display("test burst done");
    cmd(mk(1'h1, C_MRS, 3'h0, 16'h0002), sdcd_pkg::CMD_MODE_SET, 1'h0, "mrs4");
    cmd(mk(1'h1, C_ACT, 3'h1, ra), sdcd_pkg::CMD_ACTIVATE, 1'h0, "act1");
    cmd(mk(1'h1, C_RD, 3'h1, 16'h1000), sdcd_pkg::CMD_READ, 1'h0, "rd fix");
    chk(cmd_info.bl8, 1'h0, "fixed bc4");
    cmd(mk(1'h1, C_ACT, 3'h3, ra), sdcd_pkg::CMD_ACTIVATE, 1'h0, "act3");
    cmd(mk(1'h1, C_MRS, 3'h0, 16'h0), NONE, 1'h1, "mrs busy");
    cmd(mk(1'h1, C_PRE, 3'h1, 16'h0), sdcd_pkg::CMD_PRE_ONE, 1'h0, "pre1");
    st(10'h008, "bank3");
    cmd(mk(1'h1, C_PRE, 3'h1, 16'h0), sdcd_pkg::CMD_PRE_ONE, 1'h0, "pre closed");
    cmd(mk(1'h1, C_PRE, 3'h6, 16'h0400), sdcd_pkg::CMD_PRE_ALL, 1'h0, "prea");
    st(10'h000, "all closed");
    cmd(mk(1'h1, C_REF, 3'h0, 16'h0), sdcd_pkg::CMD_REFRESH, 1'h0, "ref");
    $display("test bank done");
    cmd(mk(1'h1, C_ACT, 3'h0, ra), sdcd_pkg::CMD_ACTIVATE, 1'h0, "act0");
    cmd(mk(1'h0, C_NOP, 3'h0, 16'h0), sdcd_pkg::CMD_PDOWN_IN, 1'h0, "pde");
    repeat (2) u_ctl.issue(mk(1'h0, 4'($random(seed)), 3'h0, 16'h0));
    st({sdcd_pkg::PS_PD_ACT, 8'h01}, "pd act");
    cmd(mk(1'h1, C_NOP, 3'h0, 16'h0), sdcd_pkg::CMD_PDOWN_OUT, 1'h0, "pdx");
    cmd(mk(1'h1, C_PRE, 3'h0, 16'h0400), sdcd_pkg::CMD_PRE_ALL, 1'h0, "prea");
    cmd(mk(1'h0, C_DES, 3'h0, 16'h0), sdcd_pkg::CMD_PDOWN_IN, 1'h0, "pde2");
    u_ctl.issue(mk(1'h0, C_NOP, 3'h0, 16'h0));
    st({sdcd_pkg::PS_PD_PRE, 8'h00}, "pd pre");
    cmd(mk(1'h1, C_DES, 3'h0, 16'h0), sdcd_pkg::CMD_PDOWN_OUT, 1'h0, "pdx2");
    $display("test power down done");
    cmd(mk(1'h0, C_REF, 3'h0, 16'h0), sdcd_pkg::CMD_SREF_IN, 1'h0, "sre");
    repeat (2) u_ctl.issue(mk(1'h0, C_ACT, 3'h5, 16'h0));
    st({sdcd_pkg::PS_SREF, 8'h00}, "in sref");
    v0 = nv;
    u_ctl.setp(mk(1'h1, C_NOP, 3'h0, 16'h0));
    for (k = 0; k < 20 && nv == v0; k++) @(posedge hclk);
    if (nv == v0) begin
      error_cnt++;
      give_verdict();
    end
    chk({28'h0, cmd_info.code}, {28'h0, sdcd_pkg::CMD_SREF_OUT}, "srx");
    st(10'h000, "run");
    cmd(mk(1'h1, C_NOP, 3'h0, 16'h0), NONE, 1'h0, "srx edge");
    $display("test self refresh done");
    cmd(mk(1'h1, C_ACT, 3'h4, ra), sdcd_pkg::CMD_ACTIVATE, 1'h0, "act4");
    cmd(mk(1'h1, C_REF, 3'h0, 16'h0), NONE, 1'h1, "ref busy");
    ahb(1'h0, sdcd_pkg::OFS_STATUS, 32'h0);
    chk(rd[11], 1'h1, "sticky");
    ahb(1'h1, sdcd_pkg::OFS_CTRL, 32'h0);
    cmd(mk(1'h1, C_ACT, 3'h5, ra), NONE, 1'h0, "disabled");
    ahb(1'h1, sdcd_pkg::OFS_CTRL, 32'h3);
    ahb(1'h0, sdcd_pkg::OFS_STATUS, 32'h0);
    chk(rd[11], 1'h0, "clear");
    u_ctl.set_rst(1'h0);
    repeat (10) @(posedge hclk);
    u_ctl.set_rst(1'h1);
    repeat (5) @(posedge hclk);
    st(10'h000, "mem reset");
    $display("test control done");
    give_verdict();
  end
endmodule : tb_sdcd_decoder
`default_nettype wire
